// [core/mdm_params.svh]
// Constants shared by both ends of the management serial link.
// Assumes a 50 MHz system clock on both ends.
`ifndef MDM_PARAMS_SVH
`define MDM_PARAMS_SVH

`define MDM_SYS_NS 20
`define MDM_MDC_MIN_NS 40
`define MDM_MDC_NS 160
`define MDM_MDC_CYC (`MDM_MDC_NS / `MDM_SYS_NS)
`define MDM_MDC_HALF (`MDM_MDC_CYC / 2)
`define MDM_PRE_BITS 32
`define MDM_FRAME_BITS 32
`define MDM_DATA_BITS 16
`define MDM_REG_COUNT 32
`define MDM_TA_POS 14
`define MDM_DATA_POS 16
`define MDM_STATUS_IDX 5'h01
`define MDM_SUPPRESS_BIT 6
`define MDM_REG_RST 16'h0000
`define MDM_STATUS_RST 16'h0040

`endif

// [core/mdm_pkg.sv]
// Types shared by both ends of the management serial link.
// Assumes the constants header is compiled alongside.
package mdm_pkg;

  typedef enum logic [3:0] {
    DS_UNSYNC = 4'h0,
    DS_IDLE = 4'h1,
    DS_START = 4'h2,
    DS_OP = 4'h3,
    DS_PHY = 4'h4,
    DS_REG = 4'h5,
    DS_TA = 4'h6,
    DS_DATA = 4'h7
  } mdm_dev_state_t;

  typedef enum logic [1:0] {
    SS_IDLE = 2'h0,
    SS_RUN = 2'h1
  } mdm_sta_state_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } mdm_op_t;

endpackage

// [core/mdm_if.sv]
// Two-wire management link between station and device.
// Assumes a pull-up: the data line is high unless a driver pulls it low.
`timescale 1ns/1ns
interface mdm_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;

  // Wired level with pull-up, no high impedance in design code
  assign mdio = (~sta_mdio_oe | sta_mdio_o) & (~dev_mdio_oe | dev_mdio_o);

  modport station (
    output mdc,
    output sta_mdio_o,
    output sta_mdio_oe,
    input mdio
  );

  modport device (
    input mdc,
    input mdio,
    output dev_mdio_o,
    output dev_mdio_oe
  );
endinterface

// [core/mdm_dev_end.sv]
// Device end of the management serial link with its 32-word register file.
// Assumes the station clocks the link; the link pins and the address straps
// arrive asynchronously and are synchronised to clk_sys here.
//
// Summary of operation
// - Thirty-two 16-bit registers, reached only over link
// - Station clock at most 25 MHz, no minimum
// - Shared line, device chosen by physical address
// - Station sends 32 ones to synchronise
// - Preamble may be pull-up with 32 clocks
// - Ignore everything and never drive before preamble
// - Stay synchronised until reset or invalid frame
// - Station resynchronises with 32 ones after error
// - Frame starts with zero then one
// - Nobody drives first read turnaround bit
// - Matching read: drive zero, then 16 bits
// - Write turnaround one-zero from station, device silent
// - Status register bit 6 reads one
// - Later frames need no preamble
// - At least one idle bit between frames
`timescale 1ns/1ns
`include "mdm_params.svh"
module mdm_dev_end
  import mdm_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Management link
  mdm_if.device link,
  // Local side
  input wire logic [4:0] phy_addr,
  output logic synced,
  output logic wr_stb,
  output logic [4:0] wr_addr,
  output logic [15:0] wr_data
);

  logic mdc_s1_q;
  logic mdc_s2_q;
  logic mdc_s3_q;
  logic mdio_s1_q;
  logic mdio_s2_q;
  logic [4:0] pa_s1_q;
  logic [4:0] pa_s2_q;
  mdm_dev_state_t state_q;
  logic [3:0] cnt_q;
  logic [4:0] ones_q;
  logic first_q;
  logic rd_q;
  logic [4:0] phy_q;
  logic [4:0] reg_q;
  logic [15:0] sh_q;
  logic oe_q;
  logic out_q;
  logic [15:0] regs_q [0:`MDM_REG_COUNT-1];
  logic rise;
  logic bit_in;
  logic match;
  logic [4:0] reg_idx;

  // Status word with the preamble suppression capability always set
  function automatic logic [15:0] read_word(input logic [15:0] w,
                                            input logic [4:0] a);
    logic [15:0] r;
    r = w;
    if (a == `MDM_STATUS_IDX) begin
      r[`MDM_SUPPRESS_BIT] = 1'b1;
    end
    return r;
  endfunction

  // Pins are asynchronous; stage three only feeds the edge detector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
      pa_s1_q <= 5'h00;
      pa_s2_q <= 5'h00;
    end else if (ce) begin
      mdc_s1_q <= link.mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= link.mdio;
      mdio_s2_q <= mdio_s1_q;
      pa_s1_q <= phy_addr;
      pa_s2_q <= pa_s1_q;
    end
  end

  assign rise = ce & mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;
  assign match = (phy_q == pa_s2_q);
  assign reg_idx = {reg_q[3:0], bit_in};
  assign synced = (state_q != DS_UNSYNC);

  // Consecutive ones, counted only while waiting for preamble
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ones_q <= 5'h00;
    end else if (rise) begin
      if (state_q != DS_UNSYNC || !bit_in) begin
        ones_q <= 5'h00;
      end else begin
        ones_q <= ones_q + 5'h01;
      end
    end
  end

  // Frame decoder; any malformed field drops back to waiting for preamble
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DS_UNSYNC;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      phy_q <= 5'h00;
      reg_q <= 5'h00;
    end else if (rise) begin
      unique case (state_q)
        DS_UNSYNC: begin
          if (bit_in && ones_q == 5'(`MDM_PRE_BITS - 1)) begin
            state_q <= DS_IDLE;
          end
        end
        DS_IDLE: begin
          if (!bit_in) begin
            state_q <= DS_START;
          end
        end
        DS_START: begin
          cnt_q <= 4'h0;
          if (bit_in) begin
            state_q <= DS_OP;
          end else begin
            state_q <= DS_UNSYNC;
          end
        end
        DS_OP: begin
          if (cnt_q == 4'h0) begin
            first_q <= bit_in;
            cnt_q <= 4'h1;
          end else if ({first_q, bit_in} == OP_READ ||
                       {first_q, bit_in} == OP_WRITE) begin
            rd_q <= first_q;
            cnt_q <= 4'h0;
            state_q <= DS_PHY;
          end else begin
            state_q <= DS_UNSYNC;
          end
        end
        DS_PHY: begin
          phy_q <= {phy_q[3:0], bit_in};
          cnt_q <= (cnt_q == 4'h4) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == 4'h4) begin
            state_q <= DS_REG;
          end
        end
        DS_REG: begin
          reg_q <= reg_idx;
          cnt_q <= (cnt_q == 4'h4) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == 4'h4) begin
            state_q <= DS_TA;
          end
        end
        DS_TA: begin
          if (cnt_q == 4'h0) begin
            cnt_q <= 4'h1;
            if (!rd_q && !bit_in) begin
              state_q <= DS_UNSYNC;
            end
          end else begin
            cnt_q <= 4'h0;
            if (!rd_q && bit_in) begin
              state_q <= DS_UNSYNC;
            end else begin
              state_q <= DS_DATA;
            end
          end
        end
        DS_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'hF) begin
            state_q <= DS_IDLE;
          end
        end
      endcase
    end
  end

  // Data shifter: loads the read word, then shifts both ways at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 16'h0000;
    end else if (rise) begin
      if (state_q == DS_REG && cnt_q == 4'h4) begin
        sh_q <= read_word(regs_q[reg_idx], reg_idx);
      end else if ((state_q == DS_TA && cnt_q == 4'h1) ||
                   state_q == DS_DATA) begin
        sh_q <= {sh_q[14:0], bit_in};
      end
    end
  end

  // Line driver; changes just after a rising edge so the station
  // sees a settled bit at the next one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
      out_q <= 1'b1;
    end else if (rise) begin
      if (state_q == DS_TA && rd_q && match) begin
        oe_q <= 1'b1;
        out_q <= (cnt_q == 4'h0) ? 1'b0 : sh_q[15];
      end else if (state_q == DS_DATA && oe_q) begin
        oe_q <= (cnt_q != 4'hF);
        out_q <= sh_q[15];
      end else begin
        oe_q <= 1'b0;
        out_q <= 1'b1;
      end
    end
  end

  assign link.dev_mdio_oe = oe_q;
  assign link.dev_mdio_o = out_q;

  // Register file and write notification
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MDM_REG_COUNT; i++) begin
        regs_q[i] <= (i == 1) ? `MDM_STATUS_RST : `MDM_REG_RST;
      end
      wr_stb <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 16'h0000;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (rise && state_q == DS_DATA && cnt_q == 4'hF && !rd_q && match) begin
        regs_q[reg_q] <= {sh_q[14:0], bit_in};
        wr_stb <= 1'b1;
        wr_addr <= reg_q;
        wr_data <= {sh_q[14:0], bit_in};
      end
    end
  end

endmodule

// [core/mdm_sta_end.sv]
// Station end of the management serial link: makes the link clock by
// dividing clk_sys and runs one read or write frame per request.
// Assumes the device end samples on rising link clock edges.
`timescale 1ns/1ns
`include "mdm_params.svh"
module mdm_sta_end
  import mdm_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Management link
  mdm_if.station link,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_pre,
  input wire logic [4:0] req_phy,
  input wire logic [4:0] req_reg,
  input wire logic [15:0] req_wdata,
  // Response
  output logic rsp_valid,
  output logic [15:0] rsp_rdata
);

  localparam logic [2:0] HALF = 3'(`MDM_MDC_HALF);
  localparam logic [2:0] LAST = 3'(`MDM_MDC_CYC - 1);
  localparam logic [6:0] END_BIT = 7'(`MDM_PRE_BITS + `MDM_FRAME_BITS);

  logic mdio_s1_q;
  logic mdio_s2_q;
  mdm_sta_state_t state_q;
  logic [2:0] div_q;
  logic [6:0] bit_q;
  logic [31:0] frame_q;
  logic rd_q;
  logic mdc_q;
  logic oe_q;
  logic out_q;
  logic [4:0] pos;

  assign pos = 5'(bit_q - 7'(`MDM_PRE_BITS));
  assign req_ready = (state_q == SS_IDLE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else if (ce) begin
      mdio_s1_q <= link.mdio;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // Sequencer: each bit is driven at the falling edge, sampled at the rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SS_IDLE;
      div_q <= 3'h0;
      bit_q <= 7'h00;
      frame_q <= 32'h0000_0000;
      rd_q <= 1'b0;
    end else if (ce) begin
      if (state_q == SS_IDLE) begin
        div_q <= 3'h0;
        if (req_valid) begin
          state_q <= SS_RUN;
          rd_q <= ~req_write;
          // Without preamble the frame follows a single idle bit
          bit_q <= req_pre ? 7'h00 : 7'(`MDM_PRE_BITS - 1);
          frame_q <= {2'b01, req_write ? OP_WRITE : OP_READ,
                      req_phy, req_reg, 2'b10, req_wdata};
        end
      end else begin
        div_q <= (div_q == LAST) ? 3'h0 : div_q + 3'h1;
        if (div_q == LAST) begin
          if (bit_q == END_BIT) begin
            state_q <= SS_IDLE;
          end else begin
            bit_q <= bit_q + 7'h01;
          end
        end
      end
    end
  end

  // Clock and line drive; the line is released in preamble, idle and
  // in the read turnaround and data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q <= 1'b0;
      oe_q <= 1'b0;
      out_q <= 1'b1;
    end else if (ce) begin
      if (state_q == SS_IDLE) begin
        mdc_q <= 1'b0;
        oe_q <= 1'b0;
        out_q <= 1'b1;
      end else if (div_q == 3'h0) begin
        mdc_q <= 1'b0;
        if (bit_q < 7'(`MDM_PRE_BITS) || bit_q == END_BIT) begin
          oe_q <= 1'b0;
          out_q <= 1'b1;
        end else begin
          oe_q <= !(rd_q && pos >= 5'(`MDM_TA_POS));
          out_q <= frame_q[5'd31 - pos];
        end
      end else if (div_q == HALF) begin
        mdc_q <= 1'b1;
      end
    end
  end

  // Read data is taken at the rising edge of each data bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (state_q == SS_RUN && div_q == HALF && rd_q &&
          bit_q >= 7'(`MDM_PRE_BITS + `MDM_DATA_POS) && bit_q < END_BIT) begin
        rsp_rdata <= {rsp_rdata[14:0], mdio_s2_q};
      end
      if (state_q == SS_RUN && div_q == LAST && bit_q == END_BIT) begin
        rsp_valid <= 1'b1;
      end
    end
  end

  assign link.mdc = mdc_q;
  assign link.sta_mdio_oe = oe_q;
  assign link.sta_mdio_o = out_q;

endmodule

// [tb/mdm_link_checker.sv]
// Checker for the wire between the station end and the device end.
// Assumes the signals of the joining interface arrive as plain inputs.
`timescale 1ns/1ns
module mdm_link_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link signals
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio
);
  // Cycles the device has driven; a unit test cannot see a short read
  logic [7:0] oe_cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_cnt_q <= 8'h00;
    end else if (dev_mdio_oe) begin
      oe_cnt_q <= oe_cnt_q + 8'h01;
    end else begin
      oe_cnt_q <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_no_contend: assert property (!(sta_mdio_oe && dev_mdio_oe))
    else $error("both ends drive the data line");
  a_mdc_high: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
    else $error("link clock high phase not four cycles");
  a_mdc_low: assert property ($fell(mdc) |-> !mdc [*4])
    else $error("link clock low phase too short");
  a_start_code: assert property ($rose(sta_mdio_oe) |->
    !sta_mdio_o ##8 (sta_mdio_oe && sta_mdio_o))
    else $error("frame does not open with zero then one");
  a_idle_gap: assert property ($fell(sta_mdio_oe) |-> !sta_mdio_oe [*8])
    else $error("no idle bit between frames");
  a_ta_free: assert property ($rose(dev_mdio_oe) |-> !$past(sta_mdio_oe, 5))
    else $error("station drove first turnaround bit");
  a_ta_zero: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
    else $error("second turnaround bit not zero");
  a_read_len: assert property ($fell(dev_mdio_oe) |-> oe_cnt_q == 8'h88)
    else $error("device drive length not seventeen bits");
  a_dev_edge: assert property ($changed(dev_mdio_o) && dev_mdio_oe &&
    $past(dev_mdio_oe) |-> $past(mdc, 3))
    else $error("device data moved away from a rising clock");

  c_read: cover property ($fell(dev_mdio_oe));
  c_frame: cover property ($rose(sta_mdio_oe));
  c_pullup: cover property (!sta_mdio_oe && !dev_mdio_oe && mdio && mdc);
endmodule

// [tb/mdio_management_slave_test.sv]
// Bench: station and device ends face each other; a second device end
// is fed by a bench driver that breaks framing on purpose.
`timescale 1ns/1ns
module mdio_management_slave_test;
  // Clock, reset and station request
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_pre = 1'b0;
  logic [4:0] req_phy = 5'h00;
  logic [4:0] req_reg = 5'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic ce = 1'b1;
  // Observed outputs
  logic req_ready, rsp_valid, synced, wr_stb, synced_b, wr_stb_b;
  logic [15:0] rsp_rdata, wr_data, wr_data_b;
  logic [4:0] wr_addr, wr_addr_b;
  int n_fail = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n_wr_b = 0;
  int cyc = 0;
  int exp_wr = 0;
  typedef struct packed {
    logic w;
    logic p;
    logic [4:0] phy;
    logic [4:0] rg;
    logic [15:0] wd;
    logic [15:0] rd;
  } mdm_row_t;
  mdm_row_t r;
  // Write, preamble, phy, register, write data, expected read data
  mdm_row_t rows [10] = '{
    '{1'b0, 1'b1, 5'h03, 5'h01, 16'h0000, 16'h0040},
    '{1'b1, 1'b0, 5'h03, 5'h05, 16'hA5C3, 16'h0000},
    '{1'b0, 1'b0, 5'h03, 5'h05, 16'h0000, 16'hA5C3},
    '{1'b1, 1'b0, 5'h04, 5'h05, 16'h1234, 16'h0000},
    '{1'b0, 1'b0, 5'h03, 5'h05, 16'h0000, 16'hA5C3},
    '{1'b1, 1'b0, 5'h03, 5'h01, 16'h0000, 16'h0000},
    '{1'b0, 1'b0, 5'h03, 5'h01, 16'h0000, 16'h0040},
    '{1'b1, 1'b0, 5'h03, 5'h1F, 16'h8001, 16'h0000},
    '{1'b0, 1'b0, 5'h03, 5'h1F, 16'h0000, 16'h8001},
    '{1'b0, 1'b0, 5'h04, 5'h00, 16'h0000, 16'hFFFF}};
  // Bad start, opcode 00, opcode 11, write turnaround 00
  logic [31:0] bad [4] = '{32'h118ABEEF, 32'h418ABEEF, 32'h718ABEEF,
    32'h5188BEEF};

  mdm_if l1();
  mdm_if l2();
  mdm_sta_end i_mdm_sta_end (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(l1), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_pre(req_pre), .req_phy(req_phy),
    .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  mdm_dev_end i_mdm_dev_end (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(l1), .phy_addr(5'h03), .synced(synced), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data));
  mdm_dev_end i_mdm_dev_end_b (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(l2), .phy_addr(5'h03), .synced(synced_b), .wr_stb(wr_stb_b),
    .wr_addr(wr_addr_b), .wr_data(wr_data_b));
  mdm_link_checker i_mdm_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .mdc(l1.mdc), .sta_mdio_o(l1.sta_mdio_o), .sta_mdio_oe(l1.sta_mdio_oe),
    .dev_mdio_o(l1.dev_mdio_o), .dev_mdio_oe(l1.dev_mdio_oe),
    .mdio(l1.mdio));

  always #10 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; returns at the edge after rsp_valid
  task automatic xfer(input mdm_row_t t);
    int k;
    req_write <= t.w;
    req_pre <= t.p;
    req_phy <= t.phy;
    req_reg <= t.rg;
    req_wdata <= t.wd;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 700) begin
      @(posedge clk_sys);
      k++;
    end
    // A frame that never finishes counts as a mismatch
    if (k >= 700)
      chk(16'(rsp_valid), 16'h0001);
    if (!t.w)
      chk(rsp_rdata, t.rd);
  endtask

  // Bench-made link clock runs only while a bit is sent
  task automatic lbit(input logic b, input logic drv);
    l2.mdc <= 1'b0;
    l2.sta_mdio_o <= b;
    l2.sta_mdio_oe <= drv;
    repeat (4) @(posedge clk_sys);
    l2.mdc <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic pre(input int n);
    for (int i = 0; i < n; i++) lbit(1'b1, 1'b0);
  endtask

  task automatic lframe(input logic [31:0] v);
    for (int i = 31; i >= 0; i--) lbit(v[i], 1'b1);
    // Clock stands high until the next bit lowers it
    lbit(1'b1, 1'b0);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (wr_stb === 1'b1) n_wr++;
    if (wr_stb_b === 1'b1) n_wr_b++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    l2.mdc = 1'b0;
    l2.sta_mdio_o = 1'b1;
    l2.sta_mdio_oe = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      xfer(rows[i]);
      if (rows[i].w && rows[i].phy == 5'h03) begin
        exp_wr++;
        chk(16'(wr_addr), 16'(rows[i].rg));
        chk(wr_data, rows[i].wd);
      end
      chk(16'(n_wr), 16'(exp_wr));
    end
    $display("test rows done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(16'(synced), 16'h0000);
    chk(16'(req_ready), 16'h0001);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    r = '{1'b0, 1'b0, 5'h03, 5'h05, 16'h0000, 16'hFFFF};
    xfer(r);
    r = '{1'b0, 1'b1, 5'h03, 5'h05, 16'h0000, 16'h0000};
    xfer(r);
    $display("test reset done");
    pre(31);
    lframe(32'h518ABEEF);
    chk(16'(synced_b), 16'h0000);
    chk(16'(n_wr_b), 16'h0000);
    pre(32);
    repeat (8) @(posedge clk_sys);
    chk(16'(synced_b), 16'h0001);
    lframe(32'h518ABEEF);
    lframe(32'h518ABEEF);
    chk(16'(n_wr_b), 16'h0002);
    chk(16'(wr_addr_b), 16'h0002);
    chk(wr_data_b, 16'hBEEF);
    $display("test sync done");
    // Enable low: a full write frame must leave no trace
    ce <= 1'b0;
    lframe(32'h518ABEEF);
    chk(16'(synced_b), 16'h0001);
    chk(16'(n_wr_b), 16'h0002);
    ce <= 1'b1;
    $display("test freeze done");
    for (int i = 0; i < 4; i++) begin
      pre(32);
      lframe(bad[i]);
      chk(16'(synced_b), 16'h0000);
      chk(16'(n_wr_b), 16'h0002);
    end
    lframe(32'h518ABEEF);
    chk(16'(n_wr_b), 16'h0002);
    pre(32);
    lframe(32'h518ABEEF);
    chk(16'(n_wr_b), 16'h0003);
    $display("test errors done");
    give_verdict();
  end
endmodule
